//--- ees_bus_slave.sv
/*
   Two-wire serial slave front end of a byte memory: select decode, acknowledges,
   current, random and sequential reads, byte and page writes with a self-timed
   programming cycle, and a small register port.
   Assumes serial pins arrive asynchronously and the bench resolves the open-drain data line.
*/
// What this block does
// - Select byte: type code in bits 7-4, straps in 3-1, direction in bit 0.
// - Bytes travel most significant bit first.
// - Random read: write select, address, repeated START, read select, data.
// - Sequential read continues while the master acknowledges, regardless of write protect.
// - Writes are one byte or a page of up to 32, only with protect low.
// - Array is 8,192 or 4,096 bytes, address 13 or 12 bits.
// - Each accepted byte is acknowledged by pulling data low in the ninth clock.
// - Respond only when select bits match the strap inputs.
// - While power-on reset is active, ignore everything.
// - When supply drops below threshold, again ignore everything.
// - Works with bus clock up to 400 kHz.
// - Under write protect, select and address acknowledged, data bytes not.
// - STOP after write starts programming; STOP after read returns to standby.
// - In standby, wait for START and ignore all else.
// - Data sampled on rising serial clock; master changes data while clock low.
`timescale 1ns/1ps

module ees_bus_slave #(
   parameter int         ADDR_W   = ees_pkg::ADDR_W,
   parameter logic [3:0] DEV_TYPE = ees_pkg::DEV_TYPE_RST   // Arbitrary type code
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic [2:0]  select_strap_in,
   input  wire logic        write_protect_in,
   input  wire logic        por_active_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   output logic             sda_out,
   output logic             sda_oe_out,
   output logic             prog_busy_out
);

   localparam int PW = ees_pkg::PAGE_W;
   localparam int HW = ADDR_W - PW;

   // ------------------------------------------------------------------
   // Submodules and their carriers
   // ------------------------------------------------------------------
   ees_line_if                                line ();
   ees_mem_if #(.AW(ADDR_W), .DW(8))          arr ();
   ees_mem_if #(.AW(PW),     .DW(8))          pg ();

   ees_line_sync u_sync (
      .clk_in           (clk_in),
      .rst_n_in         (rst_n_in),
      .scl_in           (scl_in),
      .sda_in           (sda_in),
      .write_protect_in (write_protect_in),
      .por_active_in    (por_active_in),
      .select_strap_in  (select_strap_in),
      .line             (line)
   );

   ees_mem #(.AW(ADDR_W), .DW(8)) u_array (
      .clk_in (clk_in),
      .port   (arr)
   );

   ees_mem #(.AW(PW), .DW(8)) u_page (
      .clk_in (clk_in),
      .port   (pg)
   );

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   ees_pkg::ees_state_t state_ff;
   ees_pkg::ees_role_t  role_ff;
   ees_pkg::ees_role_t  nxt_role;
   logic [3:0]          bit_cnt_ff;
   logic [7:0]          shift_ff;
   logic [7:0]          addr_hi_ff;
   logic [ADDR_W-1:0]   ptr_ff;
   logic [HW-1:0]       page_base_ff;
   logic [ees_pkg::PAGE_BYTES-1:0] valid_ff;
   logic                rw_ff;
   logic                mack_ff;
   logic                oe_ff;
   logic [PW:0]         prog_idx_ff;
   logic [PW-1:0]       idx_q_ff;
   logic                copy_q_ff;
   logic [15:0]         wait_cnt_ff;
   logic [15:0]         prog_wait_ff;
   logic [31:0]         rdata_ff;
   logic                busy_ff;
   logic                sda_ff;

   // ------------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------------
   wire logic sel_match = (shift_ff[7:4] == DEV_TYPE) && (shift_ff[3:1] == line.strap);
   wire logic byte_done = (bit_cnt_ff == ees_pkg::BYTE_BITS);
   wire logic is_data   = (role_ff == ees_pkg::ROLE_DATA);
   wire logic is_sel    = (role_ff == ees_pkg::ROLE_SEL);
   // Select must match; data refused under protect; addresses always taken
   wire logic rx_ack    = is_sel ? sel_match : (is_data ? ~line.wp : 1'b1);
   wire logic rx_end    = (state_ff == ees_pkg::ST_RX) && line.scl_fall && byte_done;
   wire logic tx_load   = line.scl_fall &&
                          (((state_ff == ees_pkg::ST_RX_ACK) && is_sel && rw_ff) ||
                           ((state_ff == ees_pkg::ST_TX_ACK) && mack_ff));
   wire logic prog_st   = (state_ff == ees_pkg::ST_PROG);
   wire logic copy_done = prog_idx_ff[PW];
   wire logic bus_ok    = ~prog_st;
   wire logic [ADDR_W-1:0] ptr_rd_nxt = ADDR_W'(ptr_ff + 1'b1);
   // Writes roll over inside the current page
   wire logic [ADDR_W-1:0] ptr_wr_nxt = {ptr_ff[ADDR_W-1:PW], PW'(ptr_ff[PW-1:0] + 1'b1)};
   wire logic [15:0] status_word = {12'h000, (state_ff != ees_pkg::ST_IDLE), busy_ff,
                                    line.wp, line.por};

   // Next byte role after an acknowledge
   always_comb begin
      unique case (role_ff)
         ees_pkg::ROLE_SEL: nxt_role = ees_pkg::ROLE_AHI;
         ees_pkg::ROLE_AHI: nxt_role = ees_pkg::ROLE_ALO;
         ees_pkg::ROLE_ALO: nxt_role = ees_pkg::ROLE_DATA;
         ees_pkg::ROLE_DATA: nxt_role = ees_pkg::ROLE_DATA;
      endcase
   end

   // ------------------------------------------------------------------
   // Memory hookup
   // ------------------------------------------------------------------
   assign pg.wr_en    = rx_end && is_data && ~line.wp && ~line.por;
   assign pg.wr_addr  = ptr_ff[PW-1:0];
   assign pg.wr_data  = shift_ff;
   assign pg.rd_addr  = prog_idx_ff[PW-1:0];
   assign arr.wr_en   = copy_q_ff && valid_ff[idx_q_ff] && ~line.por;
   assign arr.wr_addr = {page_base_ff, idx_q_ff};
   assign arr.wr_data = pg.rd_data;
   assign arr.rd_addr = ptr_ff;

   // ------------------------------------------------------------------
   // Serial protocol engine
   // ------------------------------------------------------------------
   // Power reset wins over every bus event; STOP over START in the same cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_ff   <= ees_pkg::ST_IDLE;
         role_ff    <= ees_pkg::ROLE_SEL;
         bit_cnt_ff <= 4'h0;
         shift_ff   <= 8'h00;
         addr_hi_ff <= 8'h00;
         ptr_ff     <= '0;
         rw_ff      <= 1'b0;
         mack_ff    <= 1'b0;
         oe_ff      <= 1'b0;
      end else if (line.por) begin
         state_ff <= ees_pkg::ST_IDLE;
         oe_ff    <= 1'b0;
      end else if (line.stop && bus_ok) begin
         oe_ff    <= 1'b0;
         state_ff <= (valid_ff != '0) ? ees_pkg::ST_PROG : ees_pkg::ST_IDLE;
      end else if (line.start && bus_ok) begin
         state_ff   <= ees_pkg::ST_RX;
         role_ff    <= ees_pkg::ROLE_SEL;
         bit_cnt_ff <= 4'h0;
         oe_ff      <= 1'b0;
      end else if (tx_load) begin
         shift_ff   <= arr.rd_data;
         oe_ff      <= ~arr.rd_data[7];
         ptr_ff     <= ptr_rd_nxt;
         bit_cnt_ff <= 4'h0;
         state_ff   <= ees_pkg::ST_TX;
      end else begin
         unique case (state_ff)
            ees_pkg::ST_IDLE: begin
            end
            ees_pkg::ST_RX: begin
               if (line.scl_rise) begin
                  shift_ff   <= {shift_ff[6:0], line.sda};
                  bit_cnt_ff <= 4'(bit_cnt_ff + 1'b1);
               end else if (rx_end) begin
                  oe_ff    <= rx_ack;
                  state_ff <= rx_ack ? ees_pkg::ST_RX_ACK : ees_pkg::ST_IDLE;
                  if (is_sel) begin
                     rw_ff <= shift_ff[0];
                  end
                  if (role_ff == ees_pkg::ROLE_AHI) begin
                     addr_hi_ff <= shift_ff;
                  end
                  if (role_ff == ees_pkg::ROLE_ALO) begin
                     ptr_ff <= ADDR_W'({addr_hi_ff, shift_ff});
                  end
                  if (is_data && rx_ack) begin
                     ptr_ff <= ptr_wr_nxt;
                  end
               end
            end
            ees_pkg::ST_RX_ACK: begin
               if (line.scl_fall) begin
                  oe_ff      <= 1'b0;
                  bit_cnt_ff <= 4'h0;
                  role_ff    <= nxt_role;
                  state_ff   <= ees_pkg::ST_RX;
               end
            end
            ees_pkg::ST_TX: begin
               if (line.scl_rise) begin
                  bit_cnt_ff <= 4'(bit_cnt_ff + 1'b1);
               end else if (line.scl_fall) begin
                  if (byte_done) begin
                     oe_ff    <= 1'b0;                                                // Free line for master
                     state_ff <= ees_pkg::ST_TX_ACK;
                  end else begin
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     oe_ff    <= ~shift_ff[6];
                  end
               end
            end
            ees_pkg::ST_TX_ACK: begin
               if (line.scl_rise) begin
                  mack_ff <= ~line.sda;
               end else if (line.scl_fall) begin
                  state_ff <= ees_pkg::ST_IDLE;                                       // No ack: stand by
               end
            end
            ees_pkg::ST_PROG: begin
               if (copy_done && (wait_cnt_ff == prog_wait_ff)) begin
                  state_ff <= ees_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Page buffer bookkeeping
   // ------------------------------------------------------------------
   // A fresh address discards any unfinished page; programming end empties it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || line.por) begin
         valid_ff     <= '0;
         page_base_ff <= '0;
      end else if (rx_end && (role_ff == ees_pkg::ROLE_ALO)) begin
         valid_ff <= '0;
      end else if (pg.wr_en) begin
         valid_ff[ptr_ff[PW-1:0]] <= 1'b1;
         page_base_ff             <= ptr_ff[ADDR_W-1:PW];
      end else if (prog_st && copy_done && (wait_cnt_ff == prog_wait_ff)) begin
         valid_ff <= '0;
      end
   end

   // ------------------------------------------------------------------
   // Self-timed programming: copy page, then hold busy
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !prog_st) begin
         prog_idx_ff <= '0;
         wait_cnt_ff <= 16'h0000;
      end else if (!copy_done) begin
         prog_idx_ff <= (PW+1)'(prog_idx_ff + 1'b1);
      end else begin
         wait_cnt_ff <= 16'(wait_cnt_ff + 1'b1);
      end
   end

   // Page buffer read is registered, so the array write trails by one cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         copy_q_ff <= 1'b0;
         idx_q_ff  <= '0;
      end else begin
         copy_q_ff <= prog_st && !copy_done;
         idx_q_ff  <= prog_idx_ff[PW-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         prog_wait_ff <= ees_pkg::PROG_WAIT_RST;
      end else if (reg_wr_in && (reg_addr_in == ees_pkg::REG_PROG_WAIT)) begin
         prog_wait_ff <= reg_wdata_in[15:0];
      end
   end

   // Read data valid only in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !reg_rd_in) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         unique case (reg_addr_in)
            ees_pkg::REG_STATUS:    rdata_ff <= {16'h0000, status_word};
            ees_pkg::REG_PTR:       rdata_ff <= 32'(ptr_ff);
            ees_pkg::REG_PROG_WAIT: rdata_ff <= {16'h0000, prog_wait_ff};
            default:                rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         busy_ff <= 1'b0;
         sda_ff  <= 1'b0;
      end else begin
         busy_ff <= prog_st;
         sda_ff  <= 1'b0;                                                             // Open drain: low only
      end
   end

   assign sda_out       = sda_ff;
   assign sda_oe_out    = oe_ff;
   assign prog_busy_out = busy_ff;
   assign reg_rdata_out = rdata_ff;

endmodule : ees_bus_slave

//--- ees_bus_slave_chk.sv
/*
   Port checker of the serial memory bus slave.
   Assumes the bench keeps the serial clock low six cycles and high two in each bit.
*/
`timescale 1ns/1ps

module ees_chk (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic        por_active_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [31:0] reg_rdata_out,
   input  wire logic        sda_out,
   input  wire logic        sda_oe_out,
   input  wire logic        prog_busy_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // Read of an address that holds no register
   sequence s_rd_hole;
      reg_rd_in && reg_addr_in != ees_pkg::REG_STATUS && reg_addr_in != ees_pkg::REG_PTR &&
      reg_addr_in != ees_pkg::REG_PROG_WAIT;
   endsequence
   // Clock high longer than any bit; data wire is not used, it carries our own drive
   sequence s_bus_idle;
      scl_in [*8];
   endsequence

   a_drive_low_only: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_oe_clock_low: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data line moved while clock high");
   a_por_silent: assert property (por_active_in [*6] |-> !sda_oe_out && !prog_busy_out)
      else $error("activity during power reset");
   a_prog_quiet: assert property (prog_busy_out |-> !sda_oe_out)
      else $error("bus answered while programming");
   a_busy_after_stop: assert property ($rose(prog_busy_out) |-> scl_in && sda_in)
      else $error("programming began without stop");
   a_oe_holds: assert property ($rose(sda_oe_out) |=> sda_oe_out [*5])
      else $error("acknowledge too short");
   a_idle_no_ack: assert property (s_bus_idle |-> !sda_oe_out)
      else $error("data line held on idle bus");
   a_rdata_gap: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
      else $error("read data outside read slot");
   a_hole_zero: assert property (s_rd_hole |=> reg_rdata_out == 32'h0)
      else $error("unmapped address read nonzero");
   a_ptr_width: assert property (reg_rd_in && reg_addr_in == ees_pkg::REG_PTR |=>
                                 reg_rdata_out[31:13] == 19'h0)
      else $error("pointer wider than array");
endmodule : ees_chk

bind ees_bus_slave ees_chk chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
   .sda_in(sda_in), .por_active_in(por_active_in), .reg_addr_in(reg_addr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .prog_busy_out(prog_busy_out));

//--- ees_bus_slave_test.sv
/*
   Self-checking bench of the serial memory bus slave.
   Assumes the design, checker and master model are compiled first.
*/
`timescale 1ns/1ps

module ees_bus_slave_test;
   localparam logic [3:0] DT = ees_pkg::DEV_TYPE_RST;
   localparam logic [7:0] SW = {DT, 3'h5, 1'b0};
   localparam logic [7:0] SR = {DT, 3'h5, 1'b1};
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [2:0]  strap = 3'h5;
   logic        wp = 1'b0;
   logic        por = 1'b0;
   logic [3:0]  raddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic        oe, sdo, busy, m_scl, m_oe, sda, ack;
   logic [7:0]  d;
   int          errors = 0;
   int          n_compared = 0;

   always #4 clk_in = !clk_in;
   // Wired data line with pull-up
   assign sda = !(m_oe || (oe && !sdo));
   ees_master mst (.clk_in(clk_in), .sda_in(sda), .scl_out(m_scl), .sda_oe_out(m_oe));
   ees_bus_slave uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(m_scl), .sda_in(sda),
      .select_strap_in(strap), .write_protect_in(wp), .por_active_in(por),
      .reg_addr_in(raddr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .sda_out(sdo), .sda_oe_out(oe), .prog_busy_out(busy));

   task automatic end_sim();
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_in);
      raddr <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk_in);
      raddr <= a;
      rd    <= 1'b1;
      @(posedge clk_in);
      rd    <= 1'b0;
      #1 chk(nm, exp, rdata);
   endtask : reg_rd
   task automatic wb(input logic [7:0] b, input logic exp, input string nm);
      mst.wr_byte(b, ack);
      chk(nm, 32'(exp), 32'(ack));
   endtask : wb
   task automatic sel(input logic [7:0] b, input logic exp, input string nm);
      mst.start();
      wb(b, exp, nm);
   endtask : sel
   task automatic rb(input logic ack_m, input logic [7:0] exp, input string nm);
      mst.rd_byte(ack_m, d);
      chk(nm, 32'(exp), 32'(d));
   endtask : rb
   // Stop, then programming must run and finish in bounded time
   task automatic prog_done();
      mst.stop();
      chk("busy", 32'h1, 32'(busy));
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk_in);
      if (busy !== 1'b0) begin
         errors++;
         end_sim();
      end
   endtask : prog_done

   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      reg_rd(ees_pkg::REG_PROG_WAIT, {16'h0, ees_pkg::PROG_WAIT_RST}, "wait_rst");
      reg_wr(ees_pkg::REG_PROG_WAIT, 32'h4);
      reg_rd(ees_pkg::REG_PROG_WAIT, 32'h4, "wait");
      reg_rd(4'hC, 32'h0, "hole");
      // Page write of three bytes at 0x0040
      sel(SW, 1'b1, "sel_w");
      wb(8'h00, 1'b1, "addr_hi");
      wb(8'h40, 1'b1, "addr_lo");
      for (int i = 0; i < 3; i++) wb(8'hA0 + 8'(i), 1'b1, "data");
      prog_done();
      // Random read of two bytes, then current read under protect
      sel(SW, 1'b1, "sel_w");
      wb(8'h00, 1'b1, "addr_hi");
      wb(8'h40, 1'b1, "addr_lo");
      sel(SR, 1'b1, "sel_r");
      rb(1'b1, 8'hA0, "rd0");
      rb(1'b0, 8'hA1, "rd1");
      mst.stop();
      reg_rd(ees_pkg::REG_PTR, 32'h42, "ptr");
      wp <= 1'b1;
      sel(SR, 1'b1, "sel_cur");
      rb(1'b0, 8'hA2, "rd2");
      mst.stop();
      reg_rd(ees_pkg::REG_STATUS, 32'h1 << ees_pkg::STAT_WP, "status");
      // Protected write: header acknowledged, data refused, nothing programmed
      sel(SW, 1'b1, "wp_sel");
      wb(8'h00, 1'b1, "wp_hi");
      wb(8'h40, 1'b1, "wp_lo");
      wb(8'h55, 1'b0, "wp_data");
      mst.stop();
      chk("wp_busy", 32'h0, 32'(busy));
      wp <= 1'b0;
      // Wrong strap, wrong type code, then power reset
      sel({DT, 3'h2, 1'b1}, 1'b0, "bad_strap");
      mst.stop();
      sel({~DT, 3'h5, 1'b1}, 1'b0, "bad_type");
      mst.stop();
      por <= 1'b1;
      mst.tick(8);
      sel(SR, 1'b0, "por_sel");
      mst.stop();
      por <= 1'b0;
      // Every strap setting answers its own select byte
      for (int k = 0; k < 8; k++) begin
         strap <= 3'(k);
         mst.tick(8);
         sel({DT, 3'(k), 1'b0}, 1'b1, "strap_sel");
         wb(8'h00, 1'b1, "strap_hi");
         wb(8'h40, 1'b1, "strap_lo");
         sel({DT, 3'(k), 1'b1}, 1'b1, "strap_selr");
         rb(1'b0, 8'hA0, "strap_rd");
         mst.stop();
      end
      end_sim();
   end
endmodule : ees_bus_slave_test

//--- ees_if.sv
/*
   Interfaces between the modules of the serial memory bus slave: the conditioned bus lines
   and a simple memory port.
   Assumes all users run on the one system clock.
*/
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Conditioned bus lines and events
// ----------------------------------------------------------------------
interface ees_line_if;
   logic       scl_rise;
   logic       scl_fall;
   logic       start;
   logic       stop;
   logic       sda;
   logic       wp;
   logic       por;
   logic [2:0] strap;
   modport src (output scl_rise, scl_fall, start, stop, sda, wp, por, strap);
   modport dst (input  scl_rise, scl_fall, start, stop, sda, wp, por, strap);
endinterface : ees_line_if

// ----------------------------------------------------------------------
// Memory port: one write, one registered read
// ----------------------------------------------------------------------
interface ees_mem_if #(parameter int AW = 13, parameter int DW = 8);
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
   modport mem  (input  wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : ees_mem_if

//--- ees_line_sync.sv
/*
   Two-stage synchroniser for the bus pins and straps, with clock edge and
   START/STOP detection on the synchronised levels.
   Assumes the system clock is far faster than the serial clock.
*/
`timescale 1ns/1ps

module ees_line_sync (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       write_protect_in,
   input  wire logic       por_active_in,
   input  wire logic [2:0] select_strap_in,
   ees_line_if.src         line
);

   logic [6:0] meta_ff;
   logic [6:0] sync_ff;
   logic       scl_q_ff;
   logic       sda_q_ff;

   // ------------------------------------------------------------------
   // Two flops per pin; only sync_ff is read downstream
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta_ff <= ees_pkg::SYNC_RST;
         sync_ff <= ees_pkg::SYNC_RST;
      end else begin
         meta_ff <= {select_strap_in, por_active_in, write_protect_in, sda_in, scl_in};
         sync_ff <= meta_ff;
      end
   end

   // Previous synchronised levels for edge finding
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= sync_ff[0];
         sda_q_ff <= sync_ff[1];
      end
   end

   // Edges and conditions; 8 ns sampling leaves ample margin at a 400 kHz bus clock
   assign line.scl_rise = sync_ff[0] & ~scl_q_ff;
   assign line.scl_fall = ~sync_ff[0] & scl_q_ff;
   assign line.start    = scl_q_ff & sync_ff[0] & sda_q_ff & ~sync_ff[1];
   assign line.stop     = scl_q_ff & sync_ff[0] & ~sda_q_ff & sync_ff[1];
   assign line.sda      = sync_ff[1];
   assign line.wp       = sync_ff[2];
   assign line.por      = sync_ff[3];
   assign line.strap    = sync_ff[6:4];

endmodule : ees_line_sync

//--- ees_master.sv
/*
   Behavioural two-wire bus master: clock, START, STOP and byte transfers.
   Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps

module ees_master (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_oe_out
);
   // Clock stands high between frames
   initial scl_out = 1'b1;
   initial sda_oe_out = 1'b0;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick
   // One bit of 64 ns; long low phase leaves the slave time to turn the line
   task automatic bit_x(input logic b, output logic s);
      sda_oe_out <= !b;
      tick(5);
      scl_out <= 1'b1;
      tick(2);
      s = sda_in;
      scl_out <= 1'b0;
      tick(1);
   endtask : bit_x
   task automatic start();
      sda_oe_out <= 1'b0;
      tick(5);
      scl_out <= 1'b1;
      tick(4);
      sda_oe_out <= 1'b1;
      tick(4);
      scl_out <= 1'b0;
      tick(1);
   endtask : start
   task automatic stop();
      sda_oe_out <= 1'b1;
      tick(5);
      scl_out <= 1'b1;
      tick(4);
      sda_oe_out <= 1'b0;
      tick(8);
   endtask : stop
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(b[i], s);
      bit_x(1'b1, s);
      ack = !s;
   endtask : wr_byte
   task automatic rd_byte(input logic ack_m, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(!ack_m, s);
   endtask : rd_byte
endmodule : ees_master

//--- ees_mem.sv
/*
   Byte memory with one write port and a registered read port.
   Assumes the user holds the read address steady one cycle before using the data.
*/
`timescale 1ns/1ps

module ees_mem #(
   parameter int AW = 13,
   parameter int DW = 8
) (
   input  wire logic clk_in,
   ees_mem_if.mem    port
);

   logic [DW-1:0] store [0:(1<<AW)-1];
   logic [DW-1:0] rd_ff;

   // ------------------------------------------------------------------
   // Array access; no reset, contents survive a logic reset
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (port.wr_en) begin
         store[port.wr_addr] <= port.wr_data;
      end
      rd_ff <= store[port.rd_addr];
   end

   assign port.rd_data = rd_ff;

endmodule : ees_mem

//--- ees_pkg.sv
/*
   Shared constants and types of the serial memory bus slave: register map, field positions,
   reset values, sizes and state enumerations.
   Assumes it is compiled before every other file of the block.
*/
package ees_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int          ADDR_W        = 13;     // 8,192 bytes; 12 gives 4,096 bytes
   localparam int          DATA_W        = 8;
   localparam int          PAGE_W        = 5;      // 32-byte page
   localparam int          PAGE_BYTES    = 32;
   localparam logic [3:0]  BYTE_BITS     = 4'h8;
   localparam logic [3:0]  DEV_TYPE_RST  = 4'h6;   // Arbitrary device type code

   // ------------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------------
   localparam logic [3:0]  REG_STATUS    = 4'h0;
   localparam logic [3:0]  REG_PTR       = 4'h4;
   localparam logic [3:0]  REG_PROG_WAIT = 4'h8;
   localparam int          STAT_POR      = 0;
   localparam int          STAT_WP       = 1;
   localparam int          STAT_BUSY     = 2;
   localparam int          STAT_ACTIVE   = 3;
   localparam logic [15:0] PROG_WAIT_RST = 16'h0100;  // Cycles of programming after copy
   localparam logic [6:0]  SYNC_RST      = 7'h7F;     // Lines idle high, power reset active

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_PROG
   } ees_state_t;

   typedef enum logic [1:0] {
      ROLE_SEL, ROLE_AHI, ROLE_ALO, ROLE_DATA
   } ees_role_t;

endpackage : ees_pkg
